// file: isadec_pkg.sv
`default_nettype none
package isadec_pkg;
   // instruction fields
   localparam int OP_HI = 31;
   localparam int OP_LO = 26;
   localparam int RS_HI = 25;
   localparam int RS_LO = 21;
   localparam int RT_HI = 20;
   localparam int RT_LO = 16;
   localparam int RD_HI = 15;
   localparam int RD_LO = 11;
   localparam int SA_HI = 10;
   localparam int SA_LO = 6;
   localparam int FN_HI = 5;
   localparam int FN_LO = 0;
   localparam int ROT_BIT = 21;
   localparam int ROTV_BIT = 6;
   localparam int TF_BIT = 16;
   localparam int HINT_BIT = 10;
   // primary opcode row/column
   localparam logic [2:0] ROW_0 = 3'h0;
   localparam logic [2:0] ROW_1 = 3'h1;
   localparam logic [2:0] ROW_2 = 3'h2;
   localparam logic [2:0] ROW_3 = 3'h3;
   localparam logic [2:0] ROW_4 = 3'h4;
   localparam logic [2:0] ROW_5 = 3'h5;
   localparam logic [2:0] ROW_6 = 3'h6;
   localparam logic [2:0] ROW_7 = 3'h7;
   localparam logic [4:0] SA_EHB = 5'h03;
   localparam logic [4:0] SA_SUPERSCALAR_IDLE = 5'h01;
   localparam logic [4:0] SA_WSBH = 5'h02;
   localparam logic [4:0] SA_SEB = 5'h10;
   localparam logic [4:0] SA_SEH = 5'h18;
   localparam logic [4:0] RS_READ_SYS_CTRL_REG = 5'h00;
   localparam logic [4:0] RS_WRITE_SYS_CTRL_REG = 5'h04;
   localparam logic [4:0] RS_READ_PREV_SHADOW_REG = 5'h0a;
   localparam logic [4:0] RS_IEGRP = 5'h0b;
   localparam logic [4:0] RS_WRITE_PREV_SHADOW_REG = 5'h0e;
   localparam logic [5:0] FN_DEBUG_BREAKPOINT = 6'h3f;
   localparam logic [5:0] FN_IOFF = 6'h00;
   localparam logic [5:0] FN_ION = 6'h20;

   typedef enum logic [5:0] {
      ISA_NONE, ISA_SLL, ISA_NOP, ISA_SUPERSCALAR_IDLE, ISA_EHB, ISA_SRL, ISA_ROTR, ISA_SHIFT_RIGHT_VARIABLE, ISA_ROTATE_RIGHT_VARIABLE,
      ISA_JR, ISA_JUMP_REGISTER_BARRIER, ISA_JUMP_LINK_REGISTER, ISA_JUMP_LINK_REGISTER_BARRIER, ISA_MOVE_ON_FP_FALSE, ISA_MOVE_ON_FP_TRUE, ISA_REG_ALU,
      ISA_BRANCH_CMP, ISA_TRAP_IMM, ISA_BRANCH_LINK, ISA_ICACHE_SYNCHRONIZE, ISA_MULT_ACCUMULATE_GRP, ISA_CLZ, ISA_CLO,
      ISA_DEBUG_BREAKPOINT, ISA_EXT, ISA_INS, ISA_WSBH, ISA_SEB, ISA_SEH, ISA_READ_HW_REG,
      ISA_READ_SYS_CTRL_REG, ISA_WRITE_SYS_CTRL_REG, ISA_READ_PREV_SHADOW_REG, ISA_WRITE_PREV_SHADOW_REG, ISA_DI, ISA_EI, ISA_SYS_OP,
      ISA_FPU, ISA_FPU_IDX, ISA_UCOP, ISA_JUMP, ISA_BRANCH, ISA_BRANCH_LIKELY,
      ISA_ALU_IMM, ISA_LOAD, ISA_STORE, ISA_CACHE, ISA_PREF, ISA_LL_SC
   } isadec_op_t;

   typedef struct packed {
      logic release2;
      logic fpu64En;
      logic cop0Usable;
      logic cop1Usable;
      logic cop2Usable;
      logic debugBrkImpl;
      logic appExtImpl;
      logic ucopImpl;
   } isadec_cfg_t;

   typedef struct packed {
      logic       valid;
      isadec_op_t op;
      logic       resvInstr;
      logic       copUnusable;
      logic [1:0] copNum;
   } isadec_res_t;
endpackage : isadec_pkg
`default_nettype wire

// file: isadec_decoder.sv
// Contract
// - opcode row bits 31..29, column 28..26
// - reserved codes raise reserved instruction
// - higher level codes raise reserved instruction
// - class codes decode a further field
// - 64-bit fpu codes need mode enabled
// - partner codes trap: reserved or unusable
// - debug breakpoint optional, else reserved
// - app extension codes trap when absent
// - release-2 additions reserved on release 1
// - branch-likely still decodes valid
// - alu, sys coproc, bitfield class placement
// - alu function row/column, gaps reserved
// - reg-imm rt decode, 11/111 icache sync
// - extended arith rows 000, 100, 111/111
// - bitfield class, reserved on release 1
// - tf bit: 0 false, 1 true
// - bit 21 selects rotate on release 2
// - bit 6 selects variable rotate on release 2
// - byte shuffle sparse shift-amount decode
// - function zero splits shift/idle/barrier
// - hint field selects barrier jump forms
// - indexed fpu opcode reserved for 64-bit fpu
// - interrupt enable group: off and on
`default_nettype none
module isadec_decoder
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // fetch side
   input  wire logic                    instrValid,
   input  wire logic [31:0]             instr,
   // static options
   input  wire isadec_pkg::isadec_cfg_t cfg,
   // pipeline side
   output var isadec_pkg::isadec_res_t  result
);
   isadec_pkg::isadec_res_t next_result;
   isadec_pkg::isadec_op_t  op;
   logic                    ri;
   logic                    cu;
   logic [1:0]              cn;
   logic [2:0]              row;
   logic [2:0]              col;
   logic [2:0]              fRow;
   logic [2:0]              fCol;
   logic [4:0]              rs;
   logic [4:0]              rt;
   logic [4:0]              rd;
   logic [4:0]              sa;
   logic [5:0]              fn;

   assign row = instr[isadec_pkg::OP_HI -: 3];
   assign col = instr[isadec_pkg::OP_HI - 3 -: 3];
   assign rs = instr[isadec_pkg::RS_HI:isadec_pkg::RS_LO];
   assign rt = instr[isadec_pkg::RT_HI:isadec_pkg::RT_LO];
   assign rd = instr[isadec_pkg::RD_HI:isadec_pkg::RD_LO];
   assign sa = instr[isadec_pkg::SA_HI:isadec_pkg::SA_LO];
   assign fn = instr[isadec_pkg::FN_HI:isadec_pkg::FN_LO];
   assign fRow = fn[5:3];
   assign fCol = fn[2:0];

   always_comb
   begin
      op = isadec_pkg::ISA_NONE;
      ri = 1'b0;
      cu = 1'b0;
      cn = 2'h0;
      case ({row, col})
         6'h00:
         begin
            // register-alu class, function row/column
            op = isadec_pkg::ISA_REG_ALU;
            case (fn)
               6'h00:
               begin
                  if (rt == 5'h00 && rd == 5'h00 && sa == isadec_pkg::SA_EHB)
                     op = isadec_pkg::ISA_EHB;
                  else if (rt == 5'h00 && rd == 5'h00 && sa == isadec_pkg::SA_SUPERSCALAR_IDLE)
                     op = isadec_pkg::ISA_SUPERSCALAR_IDLE;
                  else if (rt == 5'h00 && rd == 5'h00 && sa == 5'h00)
                     op = isadec_pkg::ISA_NOP;
                  else
                     op = isadec_pkg::ISA_SLL;
               end
               6'h01:
               begin
                  op = instr[isadec_pkg::TF_BIT] ? isadec_pkg::ISA_MOVE_ON_FP_TRUE : isadec_pkg::ISA_MOVE_ON_FP_FALSE;
                  cn = 2'h1;
                  cu = !cfg.cop1Usable;
               end
               6'h02: op = (cfg.release2 && instr[isadec_pkg::ROT_BIT]) ? isadec_pkg::ISA_ROTR
                                                                       : isadec_pkg::ISA_SRL;
               6'h06: op = (cfg.release2 && instr[isadec_pkg::ROTV_BIT]) ? isadec_pkg::ISA_ROTATE_RIGHT_VARIABLE
                                                                        : isadec_pkg::ISA_SHIFT_RIGHT_VARIABLE;
               6'h08: op = instr[isadec_pkg::HINT_BIT] ? isadec_pkg::ISA_JUMP_REGISTER_BARRIER : isadec_pkg::ISA_JR;
               6'h09: op = instr[isadec_pkg::HINT_BIT] ? isadec_pkg::ISA_JUMP_LINK_REGISTER_BARRIER : isadec_pkg::ISA_JUMP_LINK_REGISTER;
               // reserved and higher-level gaps
               6'h05, 6'h0e, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
               6'h28, 6'h29, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h35, 6'h37,
               6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f: ri = 1'b1;
               default: op = isadec_pkg::ISA_REG_ALU;
            endcase
         end
         6'h01:
         begin
            // reg-imm class by src_b field
            case (rt[4:3])
               2'h0: begin op = isadec_pkg::ISA_BRANCH_CMP; ri = rt[2]; end
               2'h1: begin op = isadec_pkg::ISA_TRAP_IMM; ri = (rt[2:0] == 3'h5 || rt[2:0] == 3'h7); end
               2'h2: begin op = isadec_pkg::ISA_BRANCH_LINK; ri = rt[2]; end
               default:
               begin
                  op = isadec_pkg::ISA_ICACHE_SYNCHRONIZE;
                  ri = !(rt[2:0] == 3'h7 && cfg.release2);
               end
            endcase
         end
         6'h02, 6'h03: op = isadec_pkg::ISA_JUMP;
         6'h04, 6'h05, 6'h06, 6'h07: op = isadec_pkg::ISA_BRANCH;
         6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f: op = isadec_pkg::ISA_ALU_IMM;
         6'h10:
         begin
            // system coprocessor class
            cn = 2'h0;
            cu = !cfg.cop0Usable;
            if (rs[4])
               op = isadec_pkg::ISA_SYS_OP;
            else
            begin
               case (rs)
                  isadec_pkg::RS_READ_SYS_CTRL_REG: op = isadec_pkg::ISA_READ_SYS_CTRL_REG;
                  isadec_pkg::RS_WRITE_SYS_CTRL_REG: op = isadec_pkg::ISA_WRITE_SYS_CTRL_REG;
                  isadec_pkg::RS_READ_PREV_SHADOW_REG: begin op = isadec_pkg::ISA_READ_PREV_SHADOW_REG; ri = !cfg.release2; end
                  isadec_pkg::RS_WRITE_PREV_SHADOW_REG: begin op = isadec_pkg::ISA_WRITE_PREV_SHADOW_REG; ri = !cfg.release2; end
                  isadec_pkg::RS_IEGRP:
                  begin
                     if (fn == isadec_pkg::FN_IOFF)
                        op = isadec_pkg::ISA_DI;
                     else if (fn == isadec_pkg::FN_ION)
                        op = isadec_pkg::ISA_EI;
                     ri = !cfg.release2 || op == isadec_pkg::ISA_NONE;
                  end
                  default: ri = 1'b1;
               endcase
            end
         end
         6'h11: begin op = isadec_pkg::ISA_FPU; cn = 2'h1; cu = !cfg.cop1Usable; end
         6'h12:
         begin
            op = isadec_pkg::ISA_UCOP;
            cn = 2'h2;
            cu = !cfg.cop2Usable;
            ri = !cfg.ucopImpl;
         end
         6'h13:
         begin
            op = isadec_pkg::ISA_FPU_IDX;
            cn = 2'h1;
            cu = !cfg.cop1Usable;
            ri = !(cfg.release2 && cfg.fpu64En);
         end
         6'h14, 6'h15, 6'h16, 6'h17: op = isadec_pkg::ISA_BRANCH_LIKELY;
         6'h1c:
         begin
            // extended arithmetic class
            case (fRow)
               3'h0: begin op = isadec_pkg::ISA_MULT_ACCUMULATE_GRP; ri = (fCol == 3'h3 || fCol > 3'h5); end
               3'h4:
               begin
                  op = (fCol == 3'h0) ? isadec_pkg::ISA_CLZ : isadec_pkg::ISA_CLO;
                  ri = fCol > 3'h1;
               end
               3'h7:
               begin
                  op = isadec_pkg::ISA_DEBUG_BREAKPOINT;
                  ri = !(fn == isadec_pkg::FN_DEBUG_BREAKPOINT && cfg.debugBrkImpl);
               end
               default: ri = 1'b1;
            endcase
         end
         6'h1d, 6'h1e: ri = !cfg.appExtImpl;
         6'h1f:
         begin
            // bitfield class, release 2 only
            case (fn)
               6'h00: op = isadec_pkg::ISA_EXT;
               6'h04: op = isadec_pkg::ISA_INS;
               6'h3b: op = isadec_pkg::ISA_READ_HW_REG;
               6'h20:
               begin
                  case (sa)
                     isadec_pkg::SA_WSBH: op = isadec_pkg::ISA_WSBH;
                     isadec_pkg::SA_SEB: op = isadec_pkg::ISA_SEB;
                     isadec_pkg::SA_SEH: op = isadec_pkg::ISA_SEH;
                     default: ri = 1'b1;
                  endcase
               end
               default: ri = 1'b1;
            endcase
            if (!cfg.release2)
               ri = 1'b1;
         end
         6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26: op = isadec_pkg::ISA_LOAD;
         6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2e: op = isadec_pkg::ISA_STORE;
         6'h2f: op = isadec_pkg::ISA_CACHE;
         6'h30, 6'h38: op = isadec_pkg::ISA_LL_SC;
         6'h33: op = isadec_pkg::ISA_PREF;
         6'h31, 6'h35, 6'h39, 6'h3d: begin op = isadec_pkg::ISA_LOAD; cn = 2'h1; cu = !cfg.cop1Usable; end
         6'h32, 6'h36, 6'h3a, 6'h3e:
         begin
            op = isadec_pkg::ISA_UCOP;
            cn = 2'h2;
            cu = !cfg.cop2Usable;
            ri = !cfg.ucopImpl;
         end
         default: ri = 1'b1;
      endcase
   end

   // trap indications exclusive with valid; unusable beats reserved
   always_comb
   begin
      next_result = '0;
      if (instrValid)
      begin
         next_result.copNum = cn;
         if (cu)
            next_result.copUnusable = 1'b1;
         else if (ri)
            next_result.resvInstr = 1'b1;
         else
         begin
            next_result.valid = 1'b1;
            next_result.op = op;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         result <= '0;
      else
         result <= next_result;
   end

   AST_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
      $onehot0({result.valid, result.resvInstr, result.copUnusable}))
      else $error("decode outcomes overlap");
   AST_R1_BITFIELD: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h1f && !cfg.release2 |=> result.resvInstr)
      else $error("bitfield class not reserved on release 1");
   AST_BLIKELY: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:28] == 4'h5 |=> result.valid && result.op == isadec_pkg::ISA_BRANCH_LIKELY)
      else $error("branch likely not valid");
   AST_ROTR: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h00 && instr[5:0] == 6'h02 && instr[21] && cfg.release2
      |=> result.op == isadec_pkg::ISA_ROTR)
      else $error("rotate not selected");
   AST_ROTATE_RIGHT_VARIABLE_R1: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h00 && instr[5:0] == 6'h06 && !cfg.release2
      |=> result.op == isadec_pkg::ISA_SHIFT_RIGHT_VARIABLE)
      else $error("release 1 variable shift not logical");
   AST_MOVE_ON_FP_TRUE: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h00 && instr[5:0] == 6'h01 && cfg.cop1Usable
      |=> result.op == ($past(instr[16]) ? isadec_pkg::ISA_MOVE_ON_FP_TRUE : isadec_pkg::ISA_MOVE_ON_FP_FALSE))
      else $error("tf select wrong");
   AST_IDX_FPU: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h13 && !cfg.fpu64En |=> !result.valid)
      else $error("indexed fpu valid without 64-bit mode");
   AST_APPEXT: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h1e && !cfg.appExtImpl |=> result.resvInstr)
      else $error("app extension code not reserved");
   AST_ICACHE_SYNCHRONIZE: assert property (@(posedge clk) disable iff (sys_rst)
      instrValid && instr[31:26] == 6'h01 && instr[20:16] == 5'h1f && cfg.release2
      |=> result.op == isadec_pkg::ISA_ICACHE_SYNCHRONIZE && result.valid)
      else $error("icache sync not decoded");
   COV_NOP: cover property (@(posedge clk) result.valid && result.op == isadec_pkg::ISA_NOP);
   COV_RI: cover property (@(posedge clk) result.resvInstr);
   COV_CU: cover property (@(posedge clk) result.copUnusable);
   COV_EI: cover property (@(posedge clk) result.valid && result.op == isadec_pkg::ISA_EI);
endmodule : isadec_decoder
`default_nettype wire

// file: isadec_fetch_model.sv
`default_nettype none
module isadec_fetch_model
(
   // clock
   input  wire logic        clk,
   // fetch side
   output var  logic        instrValid,
   output var  logic [31:0] instr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      instrValid = 1'b0;
      instr      = 32'h00000000;
   end

   // one word per call; the idle word is inverted so stale values never look valid
   task automatic send(input logic [31:0] word);
      @(posedge clk);
      instrValid <= 1'b1;
      instr      <= word;
      @(posedge clk);
      instrValid <= 1'b0;
      instr      <= ~word;
   endtask : send
endmodule : isadec_fetch_model
`default_nettype wire

// file: isadec_decoder_tb.sv
`default_nettype none
module isadec_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    clk;
   logic                    sys_rst;
   logic                    instrValid;
   logic [31:0]             instr;
   isadec_pkg::isadec_cfg_t cfg;
   isadec_pkg::isadec_res_t res;
   int                      n_errors;
   int                      samples_checked;

   isadec_fetch_model i_isadec_fetch_model (.clk(clk), .instrValid(instrValid), .instr(instr));
   isadec_decoder i_isadec_decoder (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .instr(instr),
                                    .cfg(cfg), .result(res));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // judges the answer 1 ns after the edge that takes the word
   task automatic dec(input logic [31:0] w, input logic v, input isadec_pkg::isadec_op_t op,
                      input logic r, input logic cu, input logic [1:0] cn);
      string nm;
      i_isadec_fetch_model.send(w);
      #1;
      nm = $sformatf("word %h", w);
      check({nm, " flags"}, {29'h0, res.valid, res.resvInstr, res.copUnusable}, {29'h0, v, r, cu});
      if (v)
         check({nm, " op"}, {26'h0, res.op}, {26'h0, op});
      if (cu)
         check({nm, " cop"}, {30'h0, res.copNum}, {30'h0, cn});
   endtask : dec

   task automatic ok(input logic [31:0] w, input isadec_pkg::isadec_op_t op);
      dec(w, 1'b1, op, 1'b0, 1'b0, 2'h0);
   endtask : ok

   task automatic rsv(input logic [31:0] w);
      dec(w, 1'b0, isadec_pkg::ISA_NONE, 1'b1, 1'b0, 2'h0);
   endtask : rsv

   task automatic cun(input logic [31:0] w, input logic [1:0] cn);
      dec(w, 1'b0, isadec_pkg::ISA_NONE, 1'b0, 1'b1, cn);
   endtask : cun

   // option bits: release2 fpu64 sys_coproc_class fpu_class user_coproc_class debug appext ucop
   task automatic set_cfg(input logic [7:0] c);
      @(posedge clk);
      cfg <= isadec_pkg::isadec_cfg_t'(c);
   endtask : set_cfg

   task automatic t_primary;
      check("idle result", {21'h0, res}, 32'h00000000);
      ok(32'h08000000, isadec_pkg::ISA_JUMP);
      ok(32'h20000000, isadec_pkg::ISA_ALU_IMM);
      ok(32'h8c000000, isadec_pkg::ISA_LOAD);
      ok(32'h50000000, isadec_pkg::ISA_BRANCH_LIKELY);
      rsv(32'h60000000);
      rsv(32'hec000000);
      rsv(32'h74000000);
      rsv(32'h78000000);
      $display("test primary done");
   endtask : t_primary

   task automatic t_alu;
      ok(32'h00000000, isadec_pkg::ISA_NOP);
      ok(32'h00011140, isadec_pkg::ISA_SLL);
      ok(32'h00000040, isadec_pkg::ISA_SUPERSCALAR_IDLE);
      ok(32'h000000c0, isadec_pkg::ISA_EHB);
      ok(32'h00011102, isadec_pkg::ISA_SRL);
      ok(32'h00211102, isadec_pkg::ISA_ROTR);
      ok(32'h00611006, isadec_pkg::ISA_SHIFT_RIGHT_VARIABLE);
      ok(32'h00611046, isadec_pkg::ISA_ROTATE_RIGHT_VARIABLE);
      ok(32'h03e00008, isadec_pkg::ISA_JR);
      ok(32'h03e00408, isadec_pkg::ISA_JUMP_REGISTER_BARRIER);
      ok(32'h03e0f809, isadec_pkg::ISA_JUMP_LINK_REGISTER);
      ok(32'h03e0fc09, isadec_pkg::ISA_JUMP_LINK_REGISTER_BARRIER);
      ok(32'h00401801, isadec_pkg::ISA_MOVE_ON_FP_FALSE);
      ok(32'h00411801, isadec_pkg::ISA_MOVE_ON_FP_TRUE);
      rsv(32'h00000005);
      rsv(32'h00000014);
      rsv(32'h0000003f);
      $display("test alu done");
   endtask : t_alu

   task automatic t_reg_imm_branch_class;
      ok(32'h04200000, isadec_pkg::ISA_BRANCH_CMP);
      ok(32'h04220000, isadec_pkg::ISA_BRANCH_CMP);
      ok(32'h04280000, isadec_pkg::ISA_TRAP_IMM);
      ok(32'h04300000, isadec_pkg::ISA_BRANCH_LINK);
      ok(32'h043f0000, isadec_pkg::ISA_ICACHE_SYNCHRONIZE);
      rsv(32'h04240000);
      $display("test reg_imm_branch_class done");
   endtask : t_reg_imm_branch_class

   task automatic t_arith;
      ok(32'h70000000, isadec_pkg::ISA_MULT_ACCUMULATE_GRP);
      ok(32'h70000020, isadec_pkg::ISA_CLZ);
      ok(32'h70000021, isadec_pkg::ISA_CLO);
      ok(32'h7000003f, isadec_pkg::ISA_DEBUG_BREAKPOINT);
      rsv(32'h70000003);
      rsv(32'h70000024);
      set_cfg(8'hf8);
      rsv(32'h7000003f);
      $display("test arith done");
   endtask : t_arith

   task automatic t_bitfield;
      ok(32'h7c000000, isadec_pkg::ISA_EXT);
      ok(32'h7c000004, isadec_pkg::ISA_INS);
      ok(32'h7c00003b, isadec_pkg::ISA_READ_HW_REG);
      ok(32'h7c0000a0, isadec_pkg::ISA_WSBH);
      ok(32'h7c000420, isadec_pkg::ISA_SEB);
      ok(32'h7c000620, isadec_pkg::ISA_SEH);
      rsv(32'h7c000160);
      rsv(32'h7c000008);
      $display("test bitfield done");
   endtask : t_bitfield

   task automatic t_sysco;
      ok(32'h40000000, isadec_pkg::ISA_READ_SYS_CTRL_REG);
      ok(32'h40800000, isadec_pkg::ISA_WRITE_SYS_CTRL_REG);
      ok(32'h41400000, isadec_pkg::ISA_READ_PREV_SHADOW_REG);
      ok(32'h41c00000, isadec_pkg::ISA_WRITE_PREV_SHADOW_REG);
      ok(32'h41600000, isadec_pkg::ISA_DI);
      ok(32'h41600020, isadec_pkg::ISA_EI);
      ok(32'h42000020, isadec_pkg::ISA_SYS_OP);
      rsv(32'h41600001);
      rsv(32'h40200000);
      set_cfg(8'hdc);
      cun(32'h40000000, 2'h0);
      $display("test sysco done");
   endtask : t_sysco

   task automatic t_coproc;
      ok(32'h4c000000, isadec_pkg::ISA_FPU_IDX);
      rsv(32'h48000000);
      set_cfg(8'hbc);
      rsv(32'h4c000000);
      set_cfg(8'hec);
      cun(32'h4c000000, 2'h1);
      set_cfg(8'hf4);
      cun(32'h48000000, 2'h2);
      $display("test coproc done");
   endtask : t_coproc

   // release 1: rotate bits ignored, release-2 additions refused
   task automatic t_release1;
      set_cfg(8'h7c);
      ok(32'h00211102, isadec_pkg::ISA_SRL);
      ok(32'h00611046, isadec_pkg::ISA_SHIFT_RIGHT_VARIABLE);
      rsv(32'h7c000000);
      rsv(32'h7c0000a0);
      rsv(32'h043f0000);
      rsv(32'h41400000);
      rsv(32'h41600000);
      $display("test release1 done");
   endtask : t_release1

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // roughly 70 words at two cycles each; generous margin
   initial
   begin
      #20000;
      n_errors++;
      print_verdict();
   end

   initial
   begin
      n_errors        = 0;
      samples_checked = 0;
      sys_rst         = 1'b1;
      cfg             = isadec_pkg::isadec_cfg_t'(8'hfc);
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      t_primary();
      t_alu();
      t_reg_imm_branch_class();
      t_arith();
      set_cfg(8'hfc);
      t_bitfield();
      t_sysco();
      set_cfg(8'hfc);
      t_coproc();
      t_release1();
      print_verdict();
   end
endmodule : isadec_decoder_tb
`default_nettype wire
